// >>> cssel_pkg.sv
// shared constants for the clock source and start-up selector
package cssel_pkg;
    localparam int          CNT_W      = 17;
    localparam logic [3:0]  SRC_RC_CODE  = 4'h2;
    localparam logic [1:0]  SRC_LF_HI    = 2'h1;
    localparam logic [1:0]  STARTUP_NONE = 2'h0;
    localparam logic [1:0]  STARTUP_4MS  = 2'h1;
    localparam logic [1:0]  STARTUP_65MS = 2'h2;
    localparam logic [CNT_W-1:0] RESET_CK  = 17'h0000E;
    localparam logic [CNT_W-1:0] WAKE_6    = 17'h00006;
    localparam logic [CNT_W-1:0] WAKE_258  = 17'h00102;
    localparam logic [CNT_W-1:0] WAKE_1K   = 17'h00400;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 17'h00000;
    localparam logic [3:0]  PS_DIV8    = 4'h3;
    localparam logic [3:0]  PS_DIV1    = 4'h0;
    localparam logic [6:0]  TRIM_RST   = 7'h00;
    localparam logic [3:0]  ADDR_TRIM  = 4'h0;
    localparam logic [3:0]  ADDR_PRESC = 4'h4;
    localparam logic [3:0]  ADDR_STAT  = 4'h8;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [5:0] {
        S_LOAD   = 6'h01,
        S_RTD    = 6'h02,
        S_RST_CK = 6'h04,
        S_RUN    = 6'h08,
        S_SLEEP  = 6'h10,
        S_WAKE   = 6'h20
    } cssel_state_t;
endpackage

// >>> cssel_sync.sv
// three-flop pin synchroniser giving one pulse per accepted rising edge
module cssel_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      rise_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    wire  agree = (s2_q == s3_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            s1_q   <= pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            rise_q <= agree & s3_q & ~level_q;
            if (agree) begin
                level_q <= s3_q;
            end
        end
    end
endmodule

// >>> cssel_cnt.sv
// down-counter of source ticks; load wins over a tick
module cssel_cnt
    import cssel_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    input  wire logic             tick,
    output logic      [CNT_W-1:0] count_q,
    output logic                  done
);
    assign done = (count_q == CNT_ZERO);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= CNT_ZERO;
        end else if (load) begin
            count_q <= load_val;
        end else if (tick && !done) begin
            count_q <= count_q - 17'h00001;
        end
    end
endmodule

// >>> cssel_top.sv
// clock source selection, start-up delays and rc trim register
// Functional notes
// - Crystal range follows source-select bits 3..1, codes 100 to 111.
// - Crystal wake delay is 258, 1K or 16K cycles by bit 0 and start-up.
// - Crystal reset delay is 14 cycles plus none, 4.1 ms or 65 ms.
// - Source-select codes 0100 to 0111 choose the watch-crystal oscillator.
// - Watch-crystal reset delay is 14 cycles plus none, 4.1 or 65 ms.
// - Watch-crystal wake delay is 1K for 0100/0110 and 32K for 0101/0111.
// - Source-select code 0010 chooses the internal 8 MHz rc oscillator.
// - A programmed divide-by-eight fuse divides the clock by 8 at start-up.
// - The calibration byte is loaded into the trim register during reset.
// - Rc wake is 6 cycles; reset delay is 14 cycles plus none, 4.1 or 65 ms.
// - Trim bit 7 reads zero; bits 6..0 are a writable trim value.
// - Trim zero is the slowest rc setting and 0x7F the fastest.
// - The reset time-out is always counted on the watchdog oscillator.
// - The 4.1 ms option is 4096 and the 65 ms option 65536 watchdog cycles.
// - Prescaler field resets to 0011 with the fuse programmed, else 0000.
module cssel_top
    import cssel_pkg::*;
#(
    parameter logic [CNT_W-1:0] WAKE_16K_CK  = 17'h04000,
    parameter logic [CNT_W-1:0] WAKE_32K_CK  = 17'h08000,
    parameter logic [CNT_W-1:0] WDT_4MS_CYC  = 17'h01000,
    parameter logic [CNT_W-1:0] WDT_65MS_CYC = 17'h10000
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  clock_source_select_fuses,
    input  wire logic [1:0]  startup_time_fuses,
    input  wire logic        divide_by_eight_fuse,
    input  wire logic [7:0]  factory_cal_byte,
    input  wire logic        osc_clk_pin,
    input  wire logic        wdt_osc_pin,
    input  wire logic        sleep_req,
    input  wire logic        wake_req,
    output logic             sys_clk_en_q,
    output logic             xtal_osc_en_q,
    output logic [2:0]       xtal_range_q,
    output logic             lf_osc_en_q,
    output logic             rc_osc_en_q,
    output logic [6:0]       rc_trim_value_q,
    output logic [3:0]       prescaler_select_field_q,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    cssel_state_t     state_q;
    cssel_state_t     state_d;
    logic [3:0]       src_sel_q;
    logic [1:0]       startup_q;
    logic             osc_tick;
    logic             wdt_tick;
    logic [CNT_W-1:0] osc_cnt;
    logic [CNT_W-1:0] wdt_cnt;
    logic             osc_done;
    logic             wdt_done;

    // wake cycles on the selected source
    function automatic logic [CNT_W-1:0] wake_cnt(input logic [3:0] ck,
                                                  input logic [1:0] st);
        logic [CNT_W-1:0] r;
        r = WAKE_6;
        if (ck[3]) begin
            if (!ck[0]) begin
                r = st[1] ? WAKE_1K : WAKE_258;
            end else begin
                r = (st == STARTUP_NONE) ? WAKE_1K : WAKE_16K_CK;
            end
        end else if (ck[3:2] == SRC_LF_HI) begin
            r = ck[0] ? WAKE_32K_CK : WAKE_1K;
        end
        return r;
    endfunction

    // extra reset delay in watchdog cycles; reserved code takes the longest
    function automatic logic [CNT_W-1:0] ext_cnt(input logic [3:0] ck,
                                                 input logic [1:0] st);
        logic [2:0]       k;
        logic [CNT_W-1:0] r;
        k = {ck[0], st};
        r = WDT_65MS_CYC;
        if (ck[3]) begin
            unique case (k)
                3'h0, 3'h3, 3'h6: r = WDT_4MS_CYC;
                3'h2, 3'h5:       r = CNT_ZERO;
                default:          r = WDT_65MS_CYC;
            endcase
        end else if (st == STARTUP_NONE) begin
            r = CNT_ZERO;
        end else if (st == STARTUP_4MS) begin
            r = WDT_4MS_CYC;
        end
        return r;
    endfunction

    wire fz_xtal = clock_source_select_fuses[3];
    wire fz_lf   = (clock_source_select_fuses[3:2] == SRC_LF_HI);
    wire fz_rc   = (clock_source_select_fuses == SRC_RC_CODE);
    wire [CNT_W-1:0] ext_val  = ext_cnt(clock_source_select_fuses,
                                        startup_time_fuses);
    wire [CNT_W-1:0] wake_val = wake_cnt(src_sel_q, startup_q);
    wire in_load  = (state_q == S_LOAD);
    wire wdt_load = in_load;
    wire osc_load = (state_q == S_RTD && wdt_done) ||
                    (state_q == S_SLEEP && wake_req);
    wire [CNT_W-1:0] osc_val = (state_q == S_RTD) ? RESET_CK : wake_val;

    // reset time-out runs on the watchdog oscillator, never the system source
    cssel_sync u_wdt_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (wdt_osc_pin),
        .rise_q  (wdt_tick)
    );

    cssel_sync u_osc_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (osc_clk_pin),
        .rise_q  (osc_tick)
    );

    cssel_cnt u_wdt_cnt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (wdt_load),
        .load_val (ext_val),
        .tick     (wdt_tick),
        .count_q  (wdt_cnt),
        .done     (wdt_done)
    );

    cssel_cnt u_osc_cnt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (osc_load),
        .load_val (osc_val),
        .tick     (osc_tick),
        .count_q  (osc_cnt),
        .done     (osc_done)
    );

    // start-up sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_LOAD:   state_d = S_RTD;
            S_RTD:    if (wdt_done) state_d = S_RST_CK;
            S_RST_CK: if (osc_done) state_d = S_RUN;
            S_RUN:    if (sleep_req) state_d = S_SLEEP;
            S_SLEEP:  if (wake_req) state_d = S_WAKE;
            S_WAKE:   if (osc_done) state_d = S_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q      <= S_LOAD;
            sys_clk_en_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            sys_clk_en_q <= (state_d == S_RUN);
        end
    end

    // fuses are static; caught once on the first edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_sel_q     <= SRC_RC_CODE;
            startup_q     <= STARTUP_65MS;
            xtal_osc_en_q <= 1'b0;
            xtal_range_q  <= 3'h0;
            lf_osc_en_q   <= 1'b0;
            rc_osc_en_q   <= 1'b0;
        end else if (in_load) begin
            src_sel_q     <= clock_source_select_fuses;
            startup_q     <= startup_time_fuses;
            xtal_osc_en_q <= fz_xtal;
            xtal_range_q  <= fz_xtal ?
                             clock_source_select_fuses[3:1] : 3'h0;
            lf_osc_en_q   <= fz_lf;
            rc_osc_en_q   <= fz_rc;
        end
    end

    // register bus: address and data taken together, one answer each
    logic wr_do;
    logic rd_do;
    assign wr_do = s_axi_awready;
    assign rd_do = s_axi_arready;
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~wr_do;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid & ~rd_do;
    wire [3:0] waddr = s_axi_awaddr[3:0];
    wire [3:0] raddr = s_axi_araddr[3:0];
    wire w_hit = (s_axi_awaddr[31:4] == 28'h0000000) &&
                 (waddr == ADDR_TRIM || waddr == ADDR_PRESC ||
                  waddr == ADDR_STAT);
    wire r_hit = (s_axi_araddr[31:4] == 28'h0000000) &&
                 (raddr == ADDR_TRIM || raddr == ADDR_PRESC ||
                  raddr == ADDR_STAT);
    wire wr_lo = wr_do & w_hit & s_axi_wstrb[0];
    wire [31:0] stat_word = {16'h0000, 2'h0, state_q,
                             1'b0, sys_clk_en_q, startup_q, src_sel_q};
    wire [31:0] rd_mux = (raddr == ADDR_TRIM) ?
                         {25'h0, rc_trim_value_q} :
                         (raddr == ADDR_PRESC) ?
                         {28'h0000000, prescaler_select_field_q} :
                         stat_word;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            s_axi_arready <= rd_go;
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_do) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= r_hit ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata  <= r_hit ? rd_mux : 32'h00000000;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // trim and prescaler; reset load wins over any bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_trim_value_q          <= TRIM_RST;
            prescaler_select_field_q <= PS_DIV8;
        end else if (in_load) begin
            rc_trim_value_q          <= factory_cal_byte[6:0];
            prescaler_select_field_q <= divide_by_eight_fuse ?
                                        PS_DIV1 : PS_DIV8;
        end else if (wr_lo && waddr == ADDR_TRIM) begin
            // trim drives the rc oscillator straight, 0 slowest
            rc_trim_value_q          <= s_axi_wdata[6:0];
        end else if (wr_lo && waddr == ADDR_PRESC) begin
            prescaler_select_field_q <= s_axi_wdata[3:0];
        end
    end

    chk_xtal_range: assert property (
        @(posedge aclk) disable iff (!aresetn)
        in_load && fz_xtal |=> xtal_range_q == $past(
            clock_source_select_fuses[3:1]) && xtal_osc_en_q)
        else $error("crystal range not taken from fuses");
    chk_lf_select: assert property (
        @(posedge aclk) disable iff (!aresetn)
        in_load |=> lf_osc_en_q == $past(fz_lf)
            && !(lf_osc_en_q && rc_osc_en_q))
        else $error("watch crystal selection wrong");
    chk_rc_select: assert property (
        @(posedge aclk) disable iff (!aresetn)
        in_load && clock_source_select_fuses == SRC_RC_CODE |=> rc_osc_en_q)
        else $error("rc oscillator not selected");
    chk_ext_delay: assert property (
        @(posedge aclk) disable iff (!aresetn)
        in_load |=> wdt_cnt == ext_cnt($past(clock_source_select_fuses),
                                       $past(startup_time_fuses)))
        else $error("reset delay count wrong");
    chk_wake_count: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_q == S_SLEEP && wake_req |=>
            osc_cnt == wake_cnt(src_sel_q, startup_q) && !sys_clk_en_q)
        else $error("wake delay count wrong");
    chk_wdt_only: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_q == S_RTD && !wdt_tick && !wdt_done |=> $stable(wdt_cnt))
        else $error("reset time-out moved without watchdog tick");
    chk_trim_load: assert property (
        @(posedge aclk) disable iff (!aresetn)
        in_load |=> rc_trim_value_q == $past(factory_cal_byte[6:0]))
        else $error("calibration byte not loaded");
    chk_presc_rst: assert property (
        @(posedge aclk) disable iff (!aresetn)
        in_load |=> prescaler_select_field_q ==
            ($past(divide_by_eight_fuse) ? PS_DIV1 : PS_DIV8))
        else $error("prescaler reset value wrong");
    chk_trim_msb: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_do && raddr == ADDR_TRIM && r_hit |=> s_axi_rdata[7] == 1'b0)
        else $error("trim bit 7 not zero");
    chk_gate_off: assert property (
        @(posedge aclk) disable iff (!aresetn)
        state_q == S_RST_CK && !osc_done |=> !sys_clk_en_q)
        else $error("clock released before start-up count");
endmodule

// >>> cssel_osc_model.sv
// source and watchdog oscillator pins seen by the selector
module cssel_osc_model #(
    parameter int OSC_HALF_NS = 32'hA0,
    parameter int WDT_HALF_NS = 32'hC8
) (
    input  wire logic src_en,
    output logic      osc_clk_pin,
    output logic      wdt_osc_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // odd start offsets keep both pins out of phase with aclk
    initial begin
        osc_clk_pin = 1'b0;
        #7;
        forever begin
            #(OSC_HALF_NS);
            // idle low while no source is enabled
            osc_clk_pin = src_en ? !osc_clk_pin : 1'b0;
        end
    end
    // watchdog oscillator runs free, whatever source is chosen
    initial begin
        wdt_osc_pin = 1'b0;
        #13;
        forever begin
            #(WDT_HALF_NS);
            wdt_osc_pin = !wdt_osc_pin;
        end
    end
endmodule

// >>> cssel_top_tb.sv
// self-checking bench for the clock source and start-up selector
module cssel_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cssel_pkg::*;
    localparam int PO  = 32'h8;
    localparam int PW  = 32'hA;
    localparam int W4  = 32'h8;
    localparam int W65 = 32'hC;
    localparam int K16 = 32'h14;
    localparam int K32 = 32'h18;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  clock_source_select_fuses = 4'h2;
    logic [1:0]  startup_time_fuses = 2'h0;
    logic        divide_by_eight_fuse = 1'b1;
    logic [7:0]  factory_cal_byte = 8'h00;
    logic        sleep_req = 1'b0;
    logic        wake_req = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        osc_clk_pin, wdt_osc_pin, sys_clk_en_q;
    logic        xtal_osc_en_q, lf_osc_en_q, rc_osc_en_q;
    logic [2:0]  xtal_range_q;
    logic [6:0]  rc_trim_value_q;
    logic [3:0]  prescaler_select_field_q;
    int          num_errors = 0;
    int          checked = 0;
    int          seed = 32'h04d8a154;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    logic [33:0] re;
    logic [5:0]  codes[16] = '{6'h20, 6'h21, 6'h2A, 6'h2B, 6'h34, 6'h35,
        6'h3E, 6'h3F, 6'h10, 6'h15, 6'h1A, 6'h1C, 6'h08, 6'h09, 6'h0A, 6'h0B};

    cssel_top #(.WAKE_16K_CK(17'h00014), .WAKE_32K_CK(17'h00018),
        .WDT_4MS_CYC(17'h00008), .WDT_65MS_CYC(17'h0000C)) dut_u (.*);
    cssel_osc_model osc_u (
        .src_en      (xtal_osc_en_q | lf_osc_en_q | rc_osc_en_q),
        .osc_clk_pin (osc_clk_pin),
        .wdt_osc_pin (wdt_osc_pin)
    );

    always #20 aclk = ~aclk;

    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rng(input string nm, input int t, input int lo,
                       input int hi);
        checked++;
        if (t < lo || t > hi) begin
            num_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, t);
        end
    endtask

    // bus answers are matched against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            re = rq.pop_front();
            chk("rresp", 32'(re[33:32]), 32'(s_axi_rresp));
            chk("rdata", re[31:0], s_axi_rdata);
        end
    end

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_en(output int t);
        t = 0;
        while (sys_clk_en_q !== 1'b1) begin
            @(posedge aclk);
            t++;
        end
    endtask

    function automatic int ext_of(input logic [3:0] c, input logic [1:0] s);
        logic [2:0] k;
        k = {c[0], s};
        if (c[3]) return (k == 2 || k == 5) ? 0 : (k % 3 == 0) ? W4 : W65;
        return (s == 2'h0) ? 0 : (s == 2'h1) ? W4 : W65;
    endfunction

    function automatic int wake_of(input logic [3:0] c, input logic [1:0] s);
        logic [2:0] k;
        k = {c[0], s};
        if (c[3]) return (k < 2) ? 258 : (k < 5) ? 1024 : K16;
        if (c[3:2] == 2'b01) return c[0] ? K32 : 1024;
        return 6;
    endfunction

    initial begin : main
        int t;
        int e;
        logic [3:0] c;
        logic [1:0] s;
        logic [6:0] cal;
        logic [3:0] ps;
        repeat (16) @(posedge aclk);
        foreach (codes[i]) begin
            c = codes[i][5:2];
            s = codes[i][1:0];
            cal = 7'($random(seed));
            e = ext_of(c, s);
            @(posedge aclk);
            aresetn <= 1'b0;
            clock_source_select_fuses <= c;
            startup_time_fuses <= s;
            divide_by_eight_fuse <= 1'($random(seed));
            factory_cal_byte <= {1'b1, cal};
            repeat (4) @(posedge aclk);
            aresetn <= 1'b1;
            wait_en(t);
            rng("reset_delay", t, (e > 0 ? (e - 1) * PW : 0) + 13 * PO,
                e * PW + 15 * PO + PW + 16);
            chk("xtal_en", 32'(c[3]), 32'(xtal_osc_en_q));
            chk("range", c[3] ? 32'(c[3:1]) : 0, 32'(xtal_range_q));
            chk("lf_en", 32'(c[3:2] == 2'b01), 32'(lf_osc_en_q));
            chk("rc_en", 32'(c == SRC_RC_CODE), 32'(rc_osc_en_q));
            chk("trim", 32'(cal), 32'(rc_trim_value_q));
            chk("presc", divide_by_eight_fuse ? 32'(PS_DIV1) : 32'(PS_DIV8),
                32'(prescaler_select_field_q));
            axi_rd(32'(ADDR_TRIM), 32'(cal), RESP_OKAY);
            @(posedge aclk);
            sleep_req <= 1'b1;
            @(posedge aclk);
            sleep_req <= 1'b0;
            repeat (2) @(posedge aclk);
            chk("slept", 32'h0, 32'(sys_clk_en_q));
            wake_req <= 1'b1;
            @(posedge aclk);
            wake_req <= 1'b0;
            wait_en(t);
            rng("wake_delay", t, (wake_of(c, s) - 1) * PO,
                (wake_of(c, s) + 1) * PO + 16);
        end
        // no flash writes run here, so the full trim range is allowed
        axi_wr(32'(ADDR_TRIM), 32'hFFFFFFFF, RESP_OKAY);
        axi_rd(32'(ADDR_TRIM), 32'h7F, RESP_OKAY);
        chk("trim_max", 32'h7F, 32'(rc_trim_value_q));
        // low byte lane off: the trim must keep its value
        s_axi_wstrb <= 4'hE;
        axi_wr(32'(ADDR_TRIM), 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        chk("trim_keep", 32'h7F, 32'(rc_trim_value_q));
        ps = 4'($random(seed));
        axi_wr(32'(ADDR_PRESC), 32'(ps), RESP_OKAY);
        axi_rd(32'(ADDR_PRESC), 32'(ps), RESP_OKAY);
        axi_rd(32'(ADDR_STAT), {18'h0, S_RUN, 2'b01, s, c}, RESP_OKAY);
        axi_wr(32'h10, 32'h0, RESP_SLVERR);
        axi_rd(32'h10, 32'h0, RESP_SLVERR);
        axi_wr(32'(ADDR_TRIM), 32'h0, RESP_OKAY);
        chk("trim_min", 32'h0, 32'(rc_trim_value_q));
        give_verdict();
    end

    // the longest wakes dominate; this leaves roughly double their sum
    initial begin
        repeat (95000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end
endmodule
